// >>> hw/half_flash_conversion_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Start strobe held low at least 600 ns; rise latches upper nibble.
// - Read strobe falls no sooner than 600 ns after start strobe rises.
// - Read-only: hold read strobe low until data; completion flag goes low.
// - Early read allowed 600 ns after start rise; flag drops, data presented.
// - Start strobe never held low longer than 50 us.
// - New conversion only after 500 ns of upper bank zeroing.
// - Read-only: conversion begins on read falling with chip select low.
module half_flash_conversion_sequencer #(
  parameter int DATA_W = conv_seq_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic              mode_sel,
  input  wire logic              use_int,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      result,
  output logic                   overrange,
  output logic                   timeout,
  output logic                   mode_pin,
  output logic                   cs_n,
  output logic                   wr_n,
  output logic                   rd_n,
  input  wire logic              int_n,
  input  wire logic              ready_in,
  input  wire logic              overrange_output,
  input  wire logic [DATA_W-1:0] result_bus
);

  localparam int SW = DATA_W + 3;

  conv_seq_pkg::state_t          state_r;
  conv_seq_pkg::state_t          state_nxt;
  logic [conv_seq_pkg::CNT_W-1:0] cnt_r;
  logic [conv_seq_pkg::CNT_W-1:0] rearm_r;
  logic                          mode_r;
  logic                          done_r;
  logic                          tmo_r;
  logic                          tmo_nxt;
  logic [DATA_W-1:0]             result_r;
  logic                          ovr_r;
  logic [SW-1:0]                 pin_raw;
  logic [SW-1:0]                 s1_r;
  logic [SW-1:0]                 s2_r;
  logic [SW-1:0]                 s3_r;
  logic [SW-1:0]                 filt_r;

  // Three-stage capture; a bit moves only when stages two and three agree
  assign pin_raw = {ready_in, int_n, overrange_output, result_bus};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= conv_seq_pkg::SYNC_RST;
      s2_r <= conv_seq_pkg::SYNC_RST;
      s3_r <= conv_seq_pkg::SYNC_RST;
    end
    else
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++)
    begin : g_filt
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          filt_r[gi] <= conv_seq_pkg::SYNC_RST[gi];
        else if (s2_r[gi] == s3_r[gi])
          filt_r[gi] <= s3_r[gi];
      end
    end
  endgenerate

  // Completion: flag low and, in read-only mode, ready released high
  wire int_low   = !filt_r[conv_seq_pkg::SY_INT];
  wire conv_end  = int_low && (mode_r || filt_r[conv_seq_pkg::SY_RDY]);
  wire rearm_ok  = rearm_r >= 12'(conv_seq_pkg::REARM_CYC);
  wire timed_out = cnt_r >= 12'(conv_seq_pkg::TIMEOUT_CYC);
  wire wr_len_ok = cnt_r >= 12'(conv_seq_pkg::WR_LOW_CYC - 1);
  wire gap_ok    = cnt_r >= 12'(conv_seq_pkg::READ_GAP_CYC - 1);
  wire acc_ok    = cnt_r >= 12'(conv_seq_pkg::ACCESS_CYC - 1);
  wire gap_go    = gap_ok && (!use_int || int_low || timed_out);

  always_comb
  begin
    state_nxt = state_r;
    tmo_nxt   = tmo_r;
    case (state_r)
      conv_seq_pkg::ST_IDLE:
      begin
        if (start && rearm_ok)
        begin
          tmo_nxt   = 1'b0;
          state_nxt = mode_sel ? conv_seq_pkg::ST_WR_LOW : conv_seq_pkg::ST_RD_WAIT;
        end
      end
      conv_seq_pkg::ST_WR_LOW:
        if (wr_len_ok)
          state_nxt = conv_seq_pkg::ST_WR_GAP;
      conv_seq_pkg::ST_WR_GAP:
      begin
        if (gap_go)
        begin
          tmo_nxt   = use_int && !int_low;
          state_nxt = conv_seq_pkg::ST_RD_WAIT;
        end
      end
      conv_seq_pkg::ST_RD_WAIT:
      begin
        // Write mode data follows the read strobe at once
        if (mode_r)
          state_nxt = conv_seq_pkg::ST_SETTLE;
        else if (conv_end || timed_out)
        begin
          tmo_nxt   = !conv_end;
          state_nxt = conv_seq_pkg::ST_SETTLE;
        end
      end
      conv_seq_pkg::ST_SETTLE:
        if (acc_ok)
          state_nxt = conv_seq_pkg::ST_CAPTURE;
      conv_seq_pkg::ST_CAPTURE:
        state_nxt = conv_seq_pkg::ST_IDLE;
      default:
        state_nxt = conv_seq_pkg::ST_IDLE;
    endcase
  end

  wire state_chg = state_nxt != state_r;
  wire capture   = state_r == conv_seq_pkg::ST_CAPTURE;
  wire cnt_sat   = cnt_r == conv_seq_pkg::CNT_SAT;
  wire rearm_sat = rearm_r == conv_seq_pkg::CNT_SAT;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= conv_seq_pkg::ST_IDLE;
      cnt_r   <= conv_seq_pkg::CNT_ZERO;
      tmo_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= state_chg ? conv_seq_pkg::CNT_ZERO : (cnt_sat ? cnt_r : cnt_r + conv_seq_pkg::CNT_ONE);
      tmo_r   <= tmo_nxt;
    end
  end

  // Zeroing time counts from the read strobe rising
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rearm_r <= conv_seq_pkg::CNT_SAT;
    else if (capture)
      rearm_r <= conv_seq_pkg::CNT_ZERO;
    else if (!rearm_sat)
      rearm_r <= rearm_r + conv_seq_pkg::CNT_ONE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= 1'b1;
    else if (state_r == conv_seq_pkg::ST_IDLE && start && rearm_ok)
      mode_r <= mode_sel;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_r <= '0;
      ovr_r    <= 1'b0;
      done_r   <= 1'b0;
    end
    else
    begin
      done_r <= capture;
      if (capture)
      begin
        result_r <= filt_r[DATA_W-1:0];
        ovr_r    <= filt_r[conv_seq_pkg::SY_OVR];
      end
    end
  end

  // Pin strobes decode straight from the state register
  assign cs_n      = state_r == conv_seq_pkg::ST_IDLE;
  assign wr_n      = state_r != conv_seq_pkg::ST_WR_LOW;
  assign rd_n      = !(state_r == conv_seq_pkg::ST_RD_WAIT || state_r == conv_seq_pkg::ST_SETTLE || capture);
  assign mode_pin  = mode_r;
  assign busy      = (state_r != conv_seq_pkg::ST_IDLE) || !rearm_ok;
  assign done      = done_r;
  assign result    = result_r;
  assign overrange = ovr_r;
  assign timeout   = tmo_r;

  // Helper counters watched only by the checks below
  logic [conv_seq_pkg::CNT_W-1:0] wr_low_cnt_r;
  logic [conv_seq_pkg::CNT_W-1:0] since_wr_r;
  logic [conv_seq_pkg::CNT_W-1:0] since_rd_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_low_cnt_r <= conv_seq_pkg::CNT_ZERO;
      since_wr_r   <= conv_seq_pkg::CNT_SAT;
      since_rd_r   <= conv_seq_pkg::CNT_SAT;
    end
    else
    begin
      wr_low_cnt_r <= !wr_n ? wr_low_cnt_r + conv_seq_pkg::CNT_ONE : conv_seq_pkg::CNT_ZERO;
      since_wr_r   <= !wr_n ? conv_seq_pkg::CNT_ZERO : (since_wr_r == conv_seq_pkg::CNT_SAT ? since_wr_r : since_wr_r + conv_seq_pkg::CNT_ONE);
      since_rd_r   <= !rd_n ? conv_seq_pkg::CNT_ZERO : (since_rd_r == conv_seq_pkg::CNT_SAT ? since_rd_r : since_rd_r + conv_seq_pkg::CNT_ONE);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_capture_then_release;
    capture ##1 (rd_n && done);
  endsequence

  chk_wr_min_width: assert property ($rose(wr_n) |-> $past(wr_low_cnt_r) >= 12'(conv_seq_pkg::WR_LOW_CYC - 1))
    else $error("start strobe low too short");
  chk_wr_max_width: assert property (!wr_n |-> wr_low_cnt_r < 12'(conv_seq_pkg::WR_MAX_CYC))
    else $error("start strobe low too long");
  chk_read_gap_time: assert property ($fell(rd_n) && mode_r |-> $past(since_wr_r) >= 12'(conv_seq_pkg::READ_GAP_CYC - 1))
    else $error("read strobe too soon after start rise");
  chk_rearm_wait: assert property (($fell(wr_n) || ($fell(rd_n) && !mode_r)) |-> $past(since_rd_r) >= 12'(conv_seq_pkg::REARM_CYC))
    else $error("new conversion before zeroing time");
  chk_cs_framing: assert property ((!rd_n || !wr_n) |-> !cs_n)
    else $error("strobe without chip select");
  chk_no_overlap: assert property (!(!rd_n && !wr_n))
    else $error("start and read strobes low together");
  chk_rd_release: assert property ($rose(rd_n) |-> $past(capture))
    else $error("read strobe released before capture");
  chk_capture_seq: assert property (capture |-> s_capture_then_release)
    else $error("capture not followed by release and done");
  chk_result_data: assert property (done |-> result == $past(filt_r[DATA_W-1:0]) && overrange == $past(filt_r[SW-3]))
    else $error("result differs from sampled bus");
  chk_rd_wait_end: assert property ($fell(state_r == conv_seq_pkg::ST_RD_WAIT) && !mode_r && !timeout |-> $past(conv_end))
    else $error("read-only read ended without completion");

endmodule

`default_nettype wire

// >>> hw/conv_seq_pkg.sv
package conv_seq_pkg;

  localparam int CLK_PERIOD_NS   = 20;
  localparam int WR_LOW_NS       = 600;
  localparam int WR_MAX_NS       = 50000;
  localparam int READ_GAP_NS     = 600;
  localparam int REARM_NS        = 500;
  localparam int ACCESS_NS       = 200;
  localparam int WAIT_TIMEOUT_NS = 5000;

  // Least times round up, longest times round down
  localparam int WR_LOW_CYC   = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_MAX_CYC   = WR_MAX_NS / CLK_PERIOD_NS;
  localparam int READ_GAP_CYC = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REARM_CYC    = (REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC   = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_CYC  = WAIT_TIMEOUT_NS / CLK_PERIOD_NS;

  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;
  localparam logic [CNT_W-1:0] CNT_SAT  = 12'hfff;

  localparam int DATA_W = 8;

  // Sync vector layout: result bits, overrange, completion flag, ready
  localparam int SY_OVR  = DATA_W;
  localparam int SY_INT  = DATA_W + 1;
  localparam int SY_RDY  = DATA_W + 2;
  localparam int SYNC_W  = DATA_W + 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 11'h600;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WR_LOW  = 3'b001,
    ST_WR_GAP  = 3'b010,
    ST_RD_WAIT = 3'b011,
    ST_SETTLE  = 3'b100,
    ST_CAPTURE = 3'b101
  } state_t;

endpackage

// >>> tb/conv_device_model.sv
`timescale 1ns/100ps
`default_nettype none
module conv_device_model (
  input  wire logic       cs_n,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic       mode_pin,
  input  wire logic       stall,
  input  wire logic [7:0] sample_code,
  input  wire logic       sample_ovr,
  output logic            int_n,
  output logic            ready_in,
  output logic            overrange_output,
  output logic [7:0]      result_bus,
  output int              viol_cnt
);
  logic [7:0] held_r  = 8'h00;
  logic [7:0] snap_r  = 8'h00;
  logic       ovr_r   = 1'b0;
  logic       flag_n  = 1'b1;
  logic       rd_busy = 1'b0;
  logic       rd_low  = 1'b0;
  int         seq     = 0;
  int         seq_at  = 0;
  realtime    t_wf    = 0.0;
  realtime    t_wr    = 0.0;
  realtime    t_rr    = -1.0e6;

  initial viol_cnt = 0;
  assign int_n            = flag_n;
  assign ready_in         = !rd_busy;
  assign overrange_output = ovr_r;
  // Released bus reads inverted so a stale value never passes
  assign result_bus = (!cs_n && !rd_n && !flag_n) ? held_r : ~held_r;

  task automatic complete();
    held_r = snap_r;
    flag_n = 1'b0;
  endtask

  task automatic note_start();
    if ($realtime - t_rr < 500.0) viol_cnt++;
    flag_n = 1'b1;
    seq++;
  endtask

  // Short settle so a strobe and chip select decoded together never race
  always @(negedge wr_n or negedge rd_n)
    #1 if (cs_n !== 1'b0 || (wr_n === 1'b0 && rd_n === 1'b0)) viol_cnt++;

  // Strap and strobe change on one clock edge; settle before reading the strap
  always @(negedge wr_n)
  begin
    t_wf = $realtime;
    #1;
    if (mode_pin === 1'b1 && cs_n === 1'b0)
      note_start();
  end

  always @(posedge wr_n)
  begin
    if (mode_pin === 1'b1 && cs_n === 1'b0)
    begin
      if ($realtime - t_wf < 600.0 || $realtime - t_wf > 50000.0) viol_cnt++;
      t_wr   = $realtime;
      snap_r = sample_code;
      ovr_r  = sample_ovr;
      seq_at = seq;
      #800;
      if (seq_at == seq && !stall) complete();
    end
  end

  always @(negedge rd_n)
  begin
    rd_low = 1'b1;
    #1;
    if (cs_n === 1'b0 && mode_pin)
    begin
      if ($realtime - t_wr < 600.0) viol_cnt++;
      seq++;
      if (flag_n && !stall) complete();
    end
    else if (cs_n === 1'b0)
    begin
      note_start();
      rd_busy = 1'b1;
      snap_r  = sample_code;
      ovr_r   = sample_ovr;
      seq_at  = seq;
      #1600;
      if (seq_at == seq && !stall && !rd_n)
      begin
        complete();
        rd_busy = 1'b0;
      end
    end
  end

  always @(posedge rd_n)
  begin
    flag_n  = 1'b1;
    rd_busy = 1'b0;
    // Only a real release starts zeroing; the power-up rise does not
    if (rd_low) t_rr = $realtime;
    rd_low  = 1'b0;
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       clk = 1'b0, rst_n = 1'b0, start = 1'b0, mode_sel = 1'b1;
  logic       use_int = 1'b0, stall = 1'b0, sample_ovr = 1'b0;
  logic [7:0] sample_code = 8'h00;
  logic [7:0] result, result_bus;
  logic       busy, done, overrange, timeout, mode_pin, cs_n, wr_n, rd_n, int_n, ready_in, ovr_pin;
  int         viol_cnt, num_errors = 0, checks_done = 0;

  always #(conv_seq_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  half_flash_conversion_sequencer uut (
    .clk(clk), .rst_n(rst_n), .start(start), .mode_sel(mode_sel), .use_int(use_int),
    .busy(busy), .done(done), .result(result), .overrange(overrange), .timeout(timeout),
    .mode_pin(mode_pin), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .int_n(int_n),
    .ready_in(ready_in), .overrange_output(ovr_pin), .result_bus(result_bus));

  conv_device_model dev (
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .mode_pin(mode_pin), .stall(stall),
    .sample_code(sample_code), .sample_ovr(sample_ovr), .int_n(int_n), .ready_in(ready_in),
    .overrange_output(ovr_pin), .result_bus(result_bus), .viol_cnt(viol_cnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Waits for done, or for busy to clear when want_done is low
  task automatic wait_for(input bit want_done);
    int n;
    n = 0;
    while ((want_done ? done : !busy) !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000)
    begin
      check(32'h0000_0000, 32'h0000_0001, "wait ran out");
      give_verdict();
    end
  endtask

  task automatic convert(input logic m, input logic ui, input logic st, input logic [7:0] code, input logic ov);
    wait_for(1'b0);
    mode_sel    = m;
    use_int     = ui;
    stall       = st;
    sample_code = code;
    sample_ovr  = ov;
    start       = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    wait_for(1'b1);
  endtask

  task automatic test_write_modes();
    convert(1'b1, 1'b0, 1'b0, 8'ha5, 1'b0);
    check(result, 8'ha5, "early read data");
    check(busy, 1'b1, "zeroing hold-off");
    check(mode_pin, 1'b1, "strap level");
    check(overrange, 1'b0, "overrange clear");
    convert(1'b1, 1'b1, 1'b0, 8'hff, 1'b1);
    check(result, 8'hff, "flag wait data");
    check(overrange, 1'b1, "overrange set");
    check(timeout, 1'b0, "flag in time");
    $display("test_write_modes finished");
  endtask

  task automatic test_read_only();
    convert(1'b0, 1'b0, 1'b0, 8'h3c, 1'b0);
    check(mode_pin, 1'b0, "strap level");
    check(result, 8'h3c, "read data");
    check(timeout, 1'b0, "ready released");
    $display("test_read_only finished");
  endtask

  // Device never completes; the host must give up, not hang
  task automatic test_stall();
    convert(1'b1, 1'b1, 1'b1, 8'h77, 1'b0);
    check(timeout, 1'b1, "write stall");
    convert(1'b0, 1'b0, 1'b1, 8'h77, 1'b0);
    check(timeout, 1'b1, "read stall");
    $display("test_stall finished");
  endtask

  task automatic test_back_to_back();
    wait_for(1'b0);
    mode_sel    = 1'b1;
    use_int     = 1'b0;
    stall       = 1'b0;
    sample_code = 8'h5a;
    start       = 1'b1;
    wait_for(1'b1);
    check(result, 8'h5a, "first data");
    check(timeout, 1'b0, "recovered");
    sample_code = 8'h96;
    @(negedge clk);
    wait_for(1'b1);
    start = 1'b0;
    check(result, 8'h96, "second data");
    check(viol_cnt, 32'h0000_0000, "pin timing");
    $display("test_back_to_back finished");
  endtask

  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check(cs_n, 1'b1, "idle chip select");
    check(wr_n, 1'b1, "idle start strobe");
    check(rd_n, 1'b1, "idle read strobe");
    check(busy, 1'b0, "idle busy");
    test_write_modes();
    test_read_only();
    test_stall();
    test_back_to_back();
    give_verdict();
  end
endmodule
`default_nettype wire
